/* File: rtl/pls_pkg.sv */
`default_nettype none
package pls_pkg;
  // ==================================================================
  // Sizes
  localparam int MW = 16;
  localparam int N_OC = 8;
  localparam int N_ELEM = 8;
  localparam int N_VT = 2;
  localparam int N_SEQ = 4;
  localparam int N_IRQ = 4;

  // ==================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DELAY = 8'h04;
  localparam logic [7:0] OFS_OC_ASSIGN = 8'h08;
  localparam logic [7:0] OFS_SUPV_EN = 8'h0c;
  localparam logic [7:0] OFS_VNOM = 8'h10;
  localparam logic [7:0] OFS_INOM = 8'h14;
  localparam logic [7:0] OFS_IUC = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

  // ==================================================================
  // Field positions
  localparam int CTRL_PERMIT = 0;
  localparam int CTRL_BRK_ASSIGNED = 1;
  localparam int CTRL_SEQ_ACB = 2;
  localparam int CTRL_W = 3;
  localparam int IRQ_BLOCK = 0;
  localparam int IRQ_PH_FUSE = 1;
  localparam int IRQ_GND_FUSE = 2;
  localparam int IRQ_SEQ = 3;

  // ==================================================================
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [31:0] DELAY_RST = 32'h0000_0000;
  localparam logic [MW-1:0] VNOM_RST = 16'h2710;
  localparam logic [MW-1:0] INOM_RST = 16'h03e8;
  localparam logic [MW-1:0] IUC_RST = 16'h0064;

  // ==================================================================
  // Fractions of nominal, negative sequence ratio, counter limit and step
  localparam logic [7:0] HUNDREDTH_DEN = 8'h64;
  localparam logic [7:0] TENTH_DEN = 8'h0a;
  localparam logic [7:0] RATIO_PCT = 8'h28;
  localparam logic [31:0] CNT_MAX = 32'hffff_ffff;
  localparam logic [31:0] CNT_STEP = 32'h0000_0001;

  typedef enum logic [1:0] {
    PLS_BUS_IDLE = 2'b01,
    PLS_BUS_DATA = 2'b10
  } pls_bus_t;

  typedef struct packed {
    logic [2:0][MW-1:0] v_ph;
    logic [MW-1:0] v_res;
    logic [MW-1:0] v_pos;
    logic [MW-1:0] v_neg;
    logic [2:0][MW-1:0] i_ph;
    logic [MW-1:0] i_res;
    logic [N_SEQ-1:0][MW-1:0] seq_mag;
    logic [N_SEQ-1:0][MW-1:0] seq_pos;
    logic [N_SEQ-1:0][MW-1:0] seq_neg;
  } pls_meas_t;

  typedef struct packed {
    logic [N_OC-1:0] oc_pickup;
    logic breaker_closed;
    logic dead_bus;
    logic phase_vt_fuse_input;
    logic ground_vt_fuse_input;
  } pls_cond_t;

  typedef struct packed {
    pls_bus_t bus;
    logic [7:0] addr;
    logic wr;
    logic hready;
    logic [31:0] hrdata;
    logic [CTRL_W-1:0] ctrl;
    logic [31:0] delay;
    logic [N_OC-1:0] oc_assign;
    logic [N_ELEM-1:0] supv_en;
    logic [MW-1:0] vnom;
    logic [MW-1:0] inom;
    logic [MW-1:0] iuc;
    logic [N_IRQ-1:0] irq_stat;
    logic [N_IRQ-1:0] irq_mask;
    logic [31:0] cnt;
    logic qual;
    logic blk;
    logic ff_ph;
    logic ff_gnd;
    logic [N_SEQ-1:0] seq_warn;
    logic [N_ELEM-1:0] elem_blk;
    logic irq;
  } pls_state_t;
endpackage : pls_pkg
`default_nettype wire

/* File: rtl/pls_top.sv */
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pls_top (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  input wire pls_pkg::pls_meas_t MEAS,
  input wire pls_pkg::pls_cond_t COND,
  output logic POTENTIAL_LOSS_BLOCK,
  output logic PHASE_VT_FUSE,
  output logic GROUND_VT_FUSE,
  output logic [pls_pkg::N_SEQ-1:0] SEQ_WARN,
  output logic [pls_pkg::N_ELEM-1:0] ELEM_BLOCK,
  output logic IRQ
);
  import pls_pkg::*;

  // ==================================================================
  // Helpers
  function automatic logic frac_below(input logic [MW-1:0] val,
                                      input logic [MW-1:0] nom,
                                      input logic [7:0] den);
    logic [31:0] prod;
    prod = 32'(val) * 32'(den);
    return prod < 32'(nom);
  endfunction : frac_below

  pls_state_t s;
  pls_state_t n;
  logic [N_SEQ-1:0] seq_ok_c;
  logic [N_SEQ-1:0] rot_acb_c;
  logic [N_SEQ-1:0] seq_warn_c;
  logic [N_IRQ-1:0] ev_c;
  logic any_v_low;
  logic all_i_low;
  logic vres_or_ratio;
  logic ires_low;
  logic oc_blk;
  logic brk_ok;
  logic qual_c;
  logic accept;
  logic [31:0] rd_val;

  // ==================================================================
  // Phase sequence supervision
  for (genvar k = 0; k < N_SEQ; k++) begin : g_seq
    logic [MW-1:0] nom;
    assign nom = (k < N_VT) ? s.vnom : s.inom;
    assign seq_ok_c[k] = !frac_below(MEAS.seq_mag[k], nom, TENTH_DEN);
    assign rot_acb_c[k] = MEAS.seq_neg[k] > MEAS.seq_pos[k];
    assign seq_warn_c[k] = seq_ok_c[k] &&
                           (rot_acb_c[k] != s.ctrl[CTRL_SEQ_ACB]);
  end

  // ==================================================================
  // Potential loss conditions
  always_comb begin
    any_v_low = 1'b0;
    all_i_low = 1'b1;
    for (int p = 0; p < 3; p++) begin
      any_v_low = any_v_low |
                  frac_below(MEAS.v_ph[p], s.vnom, HUNDREDTH_DEN);
      all_i_low = all_i_low & (MEAS.i_ph[p] < s.iuc);
    end
    vres_or_ratio = frac_below(MEAS.v_res, s.vnom, HUNDREDTH_DEN) ||
                    (32'(MEAS.v_neg) * 32'(HUNDREDTH_DEN) >
                     32'(MEAS.v_pos) * 32'(RATIO_PCT));
    ires_low = frac_below(MEAS.i_res, s.inom, TENTH_DEN);
    oc_blk = |(COND.oc_pickup & s.oc_assign);
    brk_ok = !s.ctrl[CTRL_BRK_ASSIGNED] || COND.breaker_closed;
    qual_c = any_v_low && vres_or_ratio && all_i_low && ires_low &&
             !oc_blk && brk_ok && !COND.dead_bus;
  end

  // ==================================================================
  // Register read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    case (s.addr)
      OFS_CTRL: rd_val = 32'(s.ctrl);
      OFS_DELAY: rd_val = s.delay;
      OFS_OC_ASSIGN: rd_val = 32'(s.oc_assign);
      OFS_SUPV_EN: rd_val = 32'(s.supv_en);
      OFS_VNOM: rd_val = 32'(s.vnom);
      OFS_INOM: rd_val = 32'(s.inom);
      OFS_IUC: rd_val = 32'(s.iuc);
      OFS_STATUS: rd_val = 32'({s.seq_warn, s.ff_gnd, s.ff_ph,
                                s.blk, s.qual});
      OFS_IRQ_STAT: rd_val = 32'(s.irq_stat);
      OFS_IRQ_MASK: rd_val = 32'(s.irq_mask);
      default: rd_val = 32'h0000_0000;
    endcase
  end

  assign accept = HSEL && HTRANS[1] && HREADY;

  // ==================================================================
  // Next state
  always_comb begin
    n = s;
    ev_c = '0;
    case (s.bus)
      PLS_BUS_IDLE: begin
        if (accept) begin
          n.bus = PLS_BUS_DATA;
          n.addr = {HADDR[7:2], 2'b00};
          n.wr = HWRITE;
          n.hready = 1'b0;
        end
      end
      PLS_BUS_DATA: begin
        // One wait state keeps read data registered
        n.bus = PLS_BUS_IDLE;
        n.hready = 1'b1;
        if (s.wr) begin
          case (s.addr)
            OFS_CTRL: n.ctrl = HWDATA[CTRL_W-1:0];
            OFS_DELAY: n.delay = HWDATA;
            OFS_OC_ASSIGN: n.oc_assign = HWDATA[N_OC-1:0];
            OFS_SUPV_EN: n.supv_en = HWDATA[N_ELEM-1:0];
            OFS_VNOM: n.vnom = HWDATA[MW-1:0];
            OFS_INOM: n.inom = HWDATA[MW-1:0];
            OFS_IUC: n.iuc = HWDATA[MW-1:0];
            OFS_IRQ_STAT: n.irq_stat = s.irq_stat & ~HWDATA[N_IRQ-1:0];
            OFS_IRQ_MASK: n.irq_mask = HWDATA[N_IRQ-1:0];
            default: n.ctrl = s.ctrl;
          endcase
        end else begin
          n.hrdata = rd_val;
        end
      end
      default: begin
        n.bus = PLS_BUS_IDLE;
        n.hready = 1'b1;
      end
    endcase

    n.qual = qual_c;
    if (!qual_c) begin
      n.cnt = '0;
    end else if (s.cnt != CNT_MAX) begin
      n.cnt = s.cnt + CNT_STEP;
    end
    n.blk = qual_c && (s.cnt >= s.delay);

    n.ff_ph = COND.phase_vt_fuse_input;
    n.ff_gnd = COND.ground_vt_fuse_input;
    n.seq_warn = seq_warn_c;

    n.elem_blk = n.supv_en & {N_ELEM{(n.blk && n.ctrl[CTRL_PERMIT]) ||
                                     n.ff_ph || n.ff_gnd}};

    ev_c[IRQ_BLOCK] = n.blk && !s.blk;
    ev_c[IRQ_PH_FUSE] = n.ff_ph && !s.ff_ph;
    ev_c[IRQ_GND_FUSE] = n.ff_gnd && !s.ff_gnd;
    ev_c[IRQ_SEQ] = |(n.seq_warn & ~s.seq_warn);
    // Set after clear so a same-cycle event survives
    n.irq_stat = n.irq_stat | ev_c;
    n.irq = |(n.irq_stat & n.irq_mask);
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      s <= '0;
      s.bus <= PLS_BUS_IDLE;
      s.hready <= 1'b1;
      s.ctrl <= CTRL_RST;
      s.delay <= DELAY_RST;
      s.vnom <= VNOM_RST;
      s.inom <= INOM_RST;
      s.iuc <= IUC_RST;
    end else if (CE) begin
      s <= n;
    end
  end

  assign HREADYOUT = s.hready;
  assign HRESP = 1'b0;
  assign HRDATA = s.hrdata;
  assign POTENTIAL_LOSS_BLOCK = s.blk;
  assign PHASE_VT_FUSE = s.ff_ph;
  assign GROUND_VT_FUSE = s.ff_gnd;
  assign SEQ_WARN = s.seq_warn;
  assign ELEM_BLOCK = s.elem_blk;
  assign IRQ = s.irq;

  // ==================================================================
  // Checks
  property p_blk_needs_qual;
    @(posedge CLK_SYS) disable iff (SRST)
      POTENTIAL_LOSS_BLOCK |-> s.qual && s.cnt > $past(s.delay);
  endproperty
  a_blk_needs_qual: assert property (p_blk_needs_qual)
    else $error("block without qualifying condition");

  property p_delay;
    @(posedge CLK_SYS) disable iff (SRST)
      CE && qual_c && s.qual && s.cnt < s.delay |=> !POTENTIAL_LOSS_BLOCK;
  endproperty
  a_delay: assert property (p_delay)
    else $error("block before delay expired");

  property p_no_v_low;
    @(posedge CLK_SYS) disable iff (SRST)
      CE && !frac_below(MEAS.v_ph[0], s.vnom, HUNDREDTH_DEN) &&
      !frac_below(MEAS.v_ph[1], s.vnom, HUNDREDTH_DEN) &&
      !frac_below(MEAS.v_ph[2], s.vnom, HUNDREDTH_DEN) |=> !s.qual;
  endproperty
  a_no_v_low: assert property (p_no_v_low)
    else $error("qualified with healthy voltages");

  property p_oc;
    @(posedge CLK_SYS) disable iff (SRST)
      CE && |(COND.oc_pickup & s.oc_assign) |=> !POTENTIAL_LOSS_BLOCK;
  endproperty
  a_oc: assert property (p_oc)
    else $error("block during assigned overcurrent pickup");

  property p_brk;
    @(posedge CLK_SYS) disable iff (SRST)
      CE && s.ctrl[CTRL_BRK_ASSIGNED] && !COND.breaker_closed |=> !s.qual;
  endproperty
  a_brk: assert property (p_brk)
    else $error("qualified with assigned breaker open");

  property p_dead;
    @(posedge CLK_SYS) disable iff (SRST)
      CE && COND.dead_bus |=> !s.qual && !POTENTIAL_LOSS_BLOCK;
  endproperty
  a_dead: assert property (p_dead)
    else $error("qualified on dead bus");

  property p_permit;
    @(posedge CLK_SYS) disable iff (SRST)
      ELEM_BLOCK != '0 |->
        (s.blk && s.ctrl[CTRL_PERMIT]) || s.ff_ph || s.ff_gnd;
  endproperty
  a_permit: assert property (p_permit)
    else $error("element blocked without permitted cause");

  property p_supv;
    @(posedge CLK_SYS) disable iff (SRST)
      (ELEM_BLOCK & ~s.supv_en) == '0;
  endproperty
  a_supv: assert property (p_supv)
    else $error("element blocked without supervision enabled");

  property p_fuse;
    @(posedge CLK_SYS) disable iff (SRST)
      CE && COND.phase_vt_fuse_input && COND.ground_vt_fuse_input |=>
        PHASE_VT_FUSE && GROUND_VT_FUSE && ELEM_BLOCK == s.supv_en;
  endproperty
  a_fuse: assert property (p_fuse)
    else $error("fuse failure not reported");

  property p_seq_min;
    @(posedge CLK_SYS) disable iff (SRST)
      CE |=> (SEQ_WARN & ~$past(seq_ok_c)) == '0;
  endproperty
  a_seq_min: assert property (p_seq_min)
    else $error("sequence warning below minimum magnitude");

  property p_blk_rise;
    @(posedge CLK_SYS) disable iff (SRST)
      CE && qual_c && s.cnt >= s.delay |=> POTENTIAL_LOSS_BLOCK;
  endproperty
  a_blk_rise: assert property (p_blk_rise)
    else $error("block missing after delay expired");

  property p_res_v;
    @(posedge CLK_SYS) disable iff (SRST)
      CE && !frac_below(MEAS.v_res, s.vnom, HUNDREDTH_DEN) &&
      32'(MEAS.v_neg) * 32'(HUNDREDTH_DEN) <=
        32'(MEAS.v_pos) * 32'(RATIO_PCT) |=> !s.qual;
  endproperty
  a_res_v: assert property (p_res_v)
    else $error("qualified with residual high and ratio low");

  property p_i_ph;
    @(posedge CLK_SYS) disable iff (SRST)
      CE && (MEAS.i_ph[0] >= s.iuc || MEAS.i_ph[1] >= s.iuc ||
             MEAS.i_ph[2] >= s.iuc) |=> !s.qual;
  endproperty
  a_i_ph: assert property (p_i_ph)
    else $error("qualified with load current flowing");

  property p_i_res;
    @(posedge CLK_SYS) disable iff (SRST)
      CE && !frac_below(MEAS.i_res, s.inom, TENTH_DEN) |=> !s.qual;
  endproperty
  a_i_res: assert property (p_i_res)
    else $error("qualified with residual current high");

  property p_ph_fuse;
    @(posedge CLK_SYS) disable iff (SRST)
      CE && COND.phase_vt_fuse_input |=>
        PHASE_VT_FUSE && ELEM_BLOCK == s.supv_en;
  endproperty
  a_ph_fuse: assert property (p_ph_fuse)
    else $error("phase fuse failure not reported");

  property p_gnd_fuse;
    @(posedge CLK_SYS) disable iff (SRST)
      CE && COND.ground_vt_fuse_input |=>
        GROUND_VT_FUSE && ELEM_BLOCK == s.supv_en;
  endproperty
  a_gnd_fuse: assert property (p_gnd_fuse)
    else $error("ground fuse failure not reported");
endmodule : pls_top
`default_nettype wire

/* File: tb/pls_fe_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pls_fe_model (
  input wire logic [3:0] mode,
  output var pls_pkg::pls_meas_t meas,
  output var pls_pkg::pls_cond_t cond
);
  import pls_pkg::*;
  // ==================================================================
  // Front end
  // Levels assume default VNOM 10000, INOM 1000, IUC 100
  always_comb begin
    meas = '0;
    cond = '0;
    meas.v_ph = {16'h2710, 16'h2710, 16'h0063};
    meas.v_pos = 16'h0064;
    cond.breaker_closed = 1'b1;
    meas.seq_mag = {16'h0063, 16'h0064, 16'h03e7, 16'h03e8};
    meas.seq_pos = {16'h0384, 16'h0384, 16'h000a, 16'h000a};
    meas.seq_neg = {16'h000a, 16'h000a, 16'h0384, 16'h0384};
    case (mode)
      4'h1: meas.v_ph[0] = 16'h0064;
      4'h2: meas.v_res = 16'h0064;
      4'h3: meas.i_ph[1] = 16'h0064;
      4'h4: meas.i_res = 16'h0064;
      4'h5: cond.oc_pickup = 8'h08;
      4'h6: cond.breaker_closed = 1'b0;
      4'h7: cond.dead_bus = 1'b1;
      4'h8: begin
        meas.v_res = 16'h0064;
        meas.v_neg = 16'h0029;
      end
      4'h9: begin
        meas.v_ph = {3{16'h2710}};
        meas.i_ph = {3{16'h03e8}};
      end
      4'ha: cond.phase_vt_fuse_input = 1'b1;
      4'hb: cond.ground_vt_fuse_input = 1'b1;
      4'hc: begin
        cond.phase_vt_fuse_input = 1'b1;
        cond.ground_vt_fuse_input = 1'b1;
      end
      default: ;
    endcase
  end
endmodule : pls_fe_model
`default_nettype wire

/* File: tb/pls_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pls_top_tb;
  import pls_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [3:0] mode = 4'h9;
  int err_total = 0;
  int num_checks = 0;
  pls_meas_t meas;
  pls_cond_t cond;
  logic hreadyout, hresp, blk, ph_f, gnd_f, irq;
  logic [31:0] hrdata;
  logic [N_SEQ-1:0] warn;
  logic [N_ELEM-1:0] eblk;

  always #2.5 clk = ~clk;

  pls_fe_model fe (.mode(mode), .meas(meas), .cond(cond));

  pls_top dut (.CLK_SYS(clk), .SRST(srst), .CE(ce), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout),
    .HRESP(hresp), .HRDATA(hrdata), .MEAS(meas), .COND(cond),
    .POTENTIAL_LOSS_BLOCK(blk), .PHASE_VT_FUSE(ph_f),
    .GROUND_VT_FUSE(gnd_f), .SEQ_WARN(warn), .ELEM_BLOCK(eblk),
    .IRQ(irq));

  // ==================================================================
  // Tasks
  task automatic end_sim;
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask : chk

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold

  // Single word transfer; waits on ready, never on a fixed count
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 80);
    q = hrdata;
    if (n >= 80) begin
      err_total++;
      $display("wrong value at %0t: bus hang", $time);
      end_sim();
    end
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string what);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, e, what);
  endtask : rd

  task automatic setm(input logic [3:0] m);
    @(posedge clk);
    mode <= m;
  endtask : setm

  // ==================================================================
  // Sequence
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(OFS_CTRL, 32'h0, "ctrl");
    rd(OFS_VNOM, 32'h2710, "vnom");
    rd(OFS_INOM, 32'h03e8, "inom");
    rd(OFS_IUC, 32'h0064, "iuc");
    rd(OFS_DELAY, 32'h0, "delay");
    rd(8'h28, 32'h0, "unmapped");
    chk({31'h0, hresp}, 32'h0, "resp");
    wr(OFS_DELAY, 32'h2);
    wr(OFS_OC_ASSIGN, 32'h08);
    wr(OFS_SUPV_EN, 32'h0f);
    wr(OFS_CTRL, 32'h3);
    setm(4'h9);
    hold(4);
    chk({31'h0, blk}, 32'h0, "healthy");
    setm(4'h0);
    hold(2);
    chk({31'h0, blk}, 32'h0, "early block");
    hold(1);
    chk({31'h0, blk}, 32'h1, "block");
    chk({24'h0, eblk}, 32'h0f, "elements");
    chk({31'h0, irq}, 32'h0, "masked irq");
    rd(OFS_IRQ_STAT, 32'h9, "irq stat");
    rd(OFS_STATUS, 32'h13, "status");
    // Each mode spoils exactly one condition
    for (int m = 1; m <= 7; m++) begin
      setm(4'(m));
      hold(6);
      chk({31'h0, blk}, 32'h0, "spoiled");
    end
    setm(4'h8);
    hold(6);
    chk({31'h0, blk}, 32'h1, "ratio");
    wr(OFS_CTRL, 32'h1);
    setm(4'h6);
    hold(6);
    chk({31'h0, blk}, 32'h1, "no breaker");
    wr(OFS_CTRL, 32'h0);
    hold(2);
    chk({24'h0, eblk}, 32'h0, "no permit");
    setm(4'ha);
    hold(2);
    chk({31'h0, ph_f}, 32'h1, "ph fuse");
    chk({24'h0, eblk}, 32'h0f, "ph fuse elem");
    setm(4'hb);
    hold(2);
    chk({31'h0, gnd_f}, 32'h1, "gnd fuse");
    chk({24'h0, eblk}, 32'h0f, "gnd fuse elem");
    setm(4'hc);
    hold(2);
    chk({30'h0, ph_f, gnd_f}, 32'h3, "both fuses");
    wr(OFS_IRQ_MASK, 32'h2);
    hold(2);
    chk({31'h0, irq}, 32'h1, "irq");
    setm(4'h9);
    wr(OFS_IRQ_STAT, 32'hf);
    hold(2);
    chk({31'h0, irq}, 32'h0, "irq clear");
    rd(OFS_IRQ_STAT, 32'h0, "stat clear");
    chk({28'h0, warn}, 32'h1, "rotation abc");
    wr(OFS_CTRL, 32'h4);
    hold(2);
    chk({28'h0, warn}, 32'h4, "rotation acb");
    // Clock enable low must freeze the persistence count
    @(posedge clk);
    ce <= 1'b0;
    mode <= 4'h0;
    hold(6);
    chk({31'h0, blk}, 32'h0, "frozen");
    @(posedge clk);
    ce <= 1'b1;
    hold(4);
    chk({31'h0, blk}, 32'h1, "resumed");
    // Second reset in mid-run
    @(posedge clk);
    srst <= 1'b1;
    hold(2);
    chk({31'h0, blk}, 32'h0, "reset block");
    chk({28'h0, warn}, 32'h0, "reset warn");
    @(posedge clk);
    srst <= 1'b0;
    rd(OFS_CTRL, 32'h0, "ctrl after reset");
    rd(OFS_DELAY, 32'h0, "delay after reset");
    end_sim();
  end
endmodule : pls_top_tb
`default_nettype wire
